// File: inc/nand_host_params.svh
`ifndef NAND_HOST_PARAMS_SVH
`define NAND_HOST_PARAMS_SVH

// Clock period of the controller clock, in ns
`define NH_CLK_NS 100
// Read access delay after the read strobe falls, in ns
`define NH_T_REA_NS 20
// Strobe-to-busy delay before ready_busy_n may be trusted, in ns
`define NH_T_WB_NS 100
// Least times round up to whole cycles, one or more for any nonzero time
`define NH_REA_CYC ((`NH_T_REA_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_WB_CYC ((`NH_T_WB_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
// Stages of the pin synchroniser
`define NH_SYNC_CYC 2

// Number of address cycles the device takes
`define NH_ADDR_CYCLES 5
// Lowest row bit and highest address bit per bus width
`define NH_X8_ROW_LSB 12
`define NH_X8_ROW_MSB 29
`define NH_X16_ROW_LSB 11
`define NH_X16_ROW_MSB 28
// Bits carried by one address cycle
`define NH_ADDR_BYTE_W 8

// Opcodes of the defined command set, packed eight bits each
`define NH_OPC_NUM 22
`define NH_OPC_LIST {8'h00, 8'h30, 8'h35, 8'h90, 8'h70, 8'hFF, 8'h80, 8'h10, \
    8'h85, 8'h60, 8'hD0, 8'h05, 8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'h78, \
    8'h06, 8'h11, 8'h81, 8'hD1}

`endif

// File: inc/nand_host_pkg.sv
package nand_host_pkg;

    // Kind of bus sequence the user asks for
    typedef enum logic [2:0] {
        OP_CMD,
        OP_ADDR,
        OP_WRITE,
        OP_READ,
        OP_WAIT_RDY
    } op_t;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_WR_FETCH,
        ST_WE_LO,
        ST_WE_HOLD,
        ST_WE_END,
        ST_RD_LO,
        ST_RD_WAIT,
        ST_RD_HI,
        ST_RDY_WAIT
    } state_t;

endpackage

// File: hw/nand_fifo.sv
`timescale 1ns/1ps
module nand_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Filling side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Draining side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW-1:0] wp_ff;  // Write pointer
    logic [AW-1:0] rp_ff;  // Read pointer
    logic [AW:0] count_ff;  // Words held
    logic ready_ff;  // Registered not-full flag, drives in_ready with no gate
    logic empty_ff;  // Registered empty flag
    logic [AW-1:0] nxt_wp;
    logic [AW-1:0] nxt_rp;
    logic [AW:0] nxt_count;
    logic nxt_full;
    logic nxt_empty;
    logic push;
    logic pop;

    assign in_ready = ready_ff;
    assign out_valid = !empty_ff;
    assign out_data = mem[rp_ff];

    // Pointer and flag update; flags are registered so ready is clean
    always_comb
    begin
        push = in_valid && ready_ff;
        pop = out_ready && !empty_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_count = count_ff;
        if (push)
        begin
            nxt_wp = (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + AW'(1);
        end
        if (pop)
        begin
            nxt_rp = (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + AW'(1);
        end
        if (push && !pop)
        begin
            nxt_count = count_ff + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            nxt_count = count_ff - (AW+1)'(1);
        end
        nxt_full = (nxt_count == (AW+1)'(DEPTH));
        nxt_empty = (nxt_count == '0);
    end

    // State registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
            count_ff <= '0;
            ready_ff <= 1'b1;
            empty_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            count_ff <= nxt_count;
            ready_ff <= !nxt_full;
            empty_ff <= nxt_empty;
        end
    end

    // Storage has no reset; contents are only read once written
    always_ff @(posedge clk)
    begin
        if (clk_en && push)
        begin
            mem[wp_ff] <= in_data;
        end
    end
endmodule

// File: hw/nand_host.sv
// Functional notes
// - Command latch high loads command register
// - Address latch high loads address register
// - One shared bus, direction set by strobes
// - x8 column in cycles one and two
// - x8 row in cycles three to five
// - x16 column in two cycles, upper lines low
// - x16 row in cycles three to five
// - Host drives unused address lines low
// - Host issues only defined opcodes
`timescale 1ns/1ps
`include "nand_host_params.svh"
module nand_host #(
    parameter int IO_W = 8,
    parameter int LEN_W = 12,
    parameter int FIFO_DEPTH = 8
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Request port
    input wire logic req_valid,
    output logic req_ready,
    input nand_host_pkg::op_t req_op,
    input wire logic [7:0] req_byte,
    input wire logic [29:0] req_addr,
    input wire logic [LEN_W-1:0] req_len,
    input wire logic program_enable,
    // Write data stream
    input wire logic [IO_W-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    // Read data stream
    output logic [IO_W-1:0] rd_data,
    output logic rd_valid,
    // Status
    output logic done,
    output logic err,
    output logic dev_ready,
    // Flash pins
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic re_n,
    output logic wp_n,
    input wire logic [IO_W-1:0] io_in,
    output logic [IO_W-1:0] io_out,
    output logic io_oe,
    input wire logic ready_busy_n
);
    localparam int ROW_LSB = (IO_W == 16) ? `NH_X16_ROW_LSB : `NH_X8_ROW_LSB;
    localparam int ROW_MSB = (IO_W == 16) ? `NH_X16_ROW_MSB : `NH_X8_ROW_MSB;
    localparam logic [3:0] RD_CYC = 4'(`NH_REA_CYC + `NH_SYNC_CYC);
    localparam logic [3:0] WB_CYC = 4'(`NH_WB_CYC);
    localparam logic [2:0] LAST_ADDR = 3'(`NH_ADDR_CYCLES - 1);

    // True for opcodes of the defined command set only
    function automatic logic opc_legal(input logic [7:0] opc);
        logic [8*`NH_OPC_NUM-1:0] list;
        logic hit;
        list = `NH_OPC_LIST;
        hit = 1'b0;
        for (int i = 0; i < `NH_OPC_NUM; i++)
        begin
            if (list[i*8 +: 8] == opc)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Byte of one address cycle; unused lines come out as zero
    function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [29:0] a);
        logic [29:0] sh;
        logic [29:0] m;
        sh = '0;
        m = 30'hFF;
        case (idx)
            3'h0: sh = a;
            3'h1:
            begin
                sh = a >> 8;
                m = (30'h1 << (ROW_LSB - 8)) - 30'h1;
            end
            3'h2: sh = a >> ROW_LSB;
            3'h3: sh = a >> (ROW_LSB + 8);
            default:
            begin
                sh = a >> (ROW_LSB + 16);
                m = (30'h1 << (ROW_MSB - ROW_LSB - 15)) - 30'h1;
            end
        endcase
        return 8'(sh & m);
    endfunction

    // Sequencer state
    nand_host_pkg::state_t state_ff;
    nand_host_pkg::state_t nxt_state;
    nand_host_pkg::op_t op_ff;  // Operation in progress
    nand_host_pkg::op_t nxt_op;
    logic [29:0] addr_ff;  // Address being sent
    logic [29:0] nxt_addr;
    logic [LEN_W-1:0] len_ff;  // Words left in a data phase
    logic [LEN_W-1:0] nxt_len;
    logic [2:0] idx_ff;  // Address cycle index
    logic [2:0] nxt_idx;
    logic [3:0] cnt_ff;  // Wait counter
    logic [3:0] nxt_cnt;
    // Registered pins and user outputs
    logic ce_n_ff, cle_ff, ale_ff, we_n_ff, re_n_ff, wp_n_ff, io_oe_ff;
    logic nxt_ce_n, nxt_cle, nxt_ale, nxt_we_n, nxt_re_n, nxt_wp_n, nxt_io_oe;
    logic [IO_W-1:0] io_out_ff;
    logic [IO_W-1:0] nxt_io_out;
    logic [IO_W-1:0] rd_data_ff;
    logic [IO_W-1:0] nxt_rd_data;
    logic rd_valid_ff, done_ff, err_ff, req_ready_ff, dev_ready_ff;
    logic nxt_rd_valid, nxt_done, nxt_err, nxt_req_ready;
    // Pin synchronisers
    logic [IO_W-1:0] io_meta_ff;
    logic [IO_W-1:0] io_sync_ff;
    logic rb_meta_ff;
    logic rb_sync_ff;
    // Write FIFO drain side
    logic [IO_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic wr_ready_w;

    nand_fifo #(
        .WIDTH(IO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .in_data(wr_data),
        .in_valid(wr_valid),
        .in_ready(wr_ready_w),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Outputs straight from flops (FIFO ready is its registered flag)
    assign {ce_n, cle, ale, we_n, re_n, wp_n} =
        {ce_n_ff, cle_ff, ale_ff, we_n_ff, re_n_ff, wp_n_ff};
    assign io_out = io_out_ff;
    assign io_oe = io_oe_ff;
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign done = done_ff;
    assign err = err_ff;
    assign req_ready = req_ready_ff;
    assign dev_ready = dev_ready_ff;
    assign wr_ready = wr_ready_w;

    // Sequencer next state: one strobe phase per cycle, slow but safe at 100 ns
    always_comb
    begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_len = len_ff;
        nxt_idx = idx_ff;
        nxt_cnt = cnt_ff;
        nxt_ce_n = ce_n_ff;
        nxt_cle = cle_ff;
        nxt_ale = ale_ff;
        nxt_we_n = we_n_ff;
        nxt_re_n = re_n_ff;
        nxt_io_out = io_out_ff;
        nxt_io_oe = io_oe_ff;
        nxt_rd_data = rd_data_ff;
        nxt_rd_valid = 1'b0;
        nxt_done = 1'b0;
        nxt_err = 1'b0;
        nxt_req_ready = req_ready_ff;
        nxt_wp_n = program_enable;
        fifo_pop = 1'b0;
        case (state_ff)
            nand_host_pkg::ST_IDLE:
            begin
                // Deselect so the device can drop into standby
                nxt_ce_n = 1'b1;
                nxt_io_oe = 1'b0;
                nxt_req_ready = 1'b1;
                if (req_valid && req_ready_ff)
                begin
                    nxt_req_ready = 1'b0;
                    nxt_op = req_op;
                    nxt_addr = req_addr;
                    nxt_len = req_len;
                    nxt_idx = '0;
                    nxt_ce_n = 1'b0;
                    case (req_op)
                        nand_host_pkg::OP_CMD:
                        begin
                            // Undefined opcodes never reach the pins
                            if (opc_legal(req_byte))
                            begin
                                nxt_cle = 1'b1;
                                nxt_io_out = IO_W'(req_byte);
                                nxt_io_oe = 1'b1;
                                nxt_state = nand_host_pkg::ST_WE_LO;
                            end
                            else
                            begin
                                nxt_ce_n = 1'b1;
                                nxt_err = 1'b1;
                                nxt_req_ready = 1'b1;
                            end
                        end
                        nand_host_pkg::OP_ADDR:
                        begin
                            nxt_ale = 1'b1;
                            nxt_io_out = IO_W'(addr_byte(3'h0, req_addr));
                            nxt_io_oe = 1'b1;
                            nxt_state = nand_host_pkg::ST_WE_LO;
                        end
                        nand_host_pkg::OP_WRITE:
                        begin
                            nxt_state = nand_host_pkg::ST_WR_FETCH;
                        end
                        nand_host_pkg::OP_READ:
                        begin
                            nxt_state = nand_host_pkg::ST_RD_LO;
                        end
                        nand_host_pkg::OP_WAIT_RDY:
                        begin
                            nxt_ce_n = 1'b1;
                            nxt_cnt = WB_CYC;
                            nxt_state = nand_host_pkg::ST_RDY_WAIT;
                        end
                        default:
                        begin
                            nxt_ce_n = 1'b1;
                            nxt_err = 1'b1;
                            nxt_req_ready = 1'b1;
                        end
                    endcase
                    // Empty data phases finish at once
                    if ((req_op == nand_host_pkg::OP_WRITE || req_op == nand_host_pkg::OP_READ)
                        && req_len == '0)
                    begin
                        nxt_ce_n = 1'b1;
                        nxt_done = 1'b1;
                        nxt_req_ready = 1'b1;
                        nxt_state = nand_host_pkg::ST_IDLE;
                    end
                end
            end
            nand_host_pkg::ST_WR_FETCH:
            begin
                // Stalls here while the FIFO is empty, back-pressuring nothing
                if (fifo_valid)
                begin
                    fifo_pop = 1'b1;
                    nxt_io_out = fifo_data;
                    nxt_io_oe = 1'b1;
                    nxt_state = nand_host_pkg::ST_WE_LO;
                end
            end
            nand_host_pkg::ST_WE_LO:
            begin
                nxt_we_n = 1'b0;
                nxt_state = nand_host_pkg::ST_WE_HOLD;
            end
            nand_host_pkg::ST_WE_HOLD:
            begin
                // Rising edge with bus stable latches the value
                nxt_we_n = 1'b1;
                nxt_state = nand_host_pkg::ST_WE_END;
            end
            nand_host_pkg::ST_WE_END:
            begin
                // Bus held one more cycle for hold time after the rise
                if (ale_ff && idx_ff != LAST_ADDR)
                begin
                    // Exactly five cycles, never more
                    nxt_idx = idx_ff + 3'h1;
                    nxt_io_out = IO_W'(addr_byte(idx_ff + 3'h1, addr_ff));
                    nxt_state = nand_host_pkg::ST_WE_LO;
                end
                else if (op_ff == nand_host_pkg::OP_WRITE && len_ff > LEN_W'(1))
                begin
                    nxt_len = len_ff - LEN_W'(1);
                    nxt_state = nand_host_pkg::ST_WR_FETCH;
                end
                else
                begin
                    nxt_cle = 1'b0;
                    nxt_ale = 1'b0;
                    nxt_io_oe = 1'b0;
                    nxt_io_out = '0;
                    nxt_ce_n = 1'b1;
                    nxt_done = 1'b1;
                    nxt_req_ready = 1'b1;
                    nxt_state = nand_host_pkg::ST_IDLE;
                end
            end
            nand_host_pkg::ST_RD_LO:
            begin
                // Release the bus before the device drives it
                nxt_io_oe = 1'b0;
                nxt_re_n = 1'b0;
                nxt_cnt = RD_CYC;
                nxt_state = nand_host_pkg::ST_RD_WAIT;
            end
            nand_host_pkg::ST_RD_WAIT:
            begin
                // Wait access delay plus synchroniser latency, then sample
                if (cnt_ff == '0)
                begin
                    nxt_rd_data = io_sync_ff;
                    nxt_rd_valid = 1'b1;
                    nxt_re_n = 1'b1;
                    nxt_state = nand_host_pkg::ST_RD_HI;
                end
                else
                begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            nand_host_pkg::ST_RD_HI:
            begin
                // Device steps its column on each pulse; host only counts
                if (len_ff > LEN_W'(1))
                begin
                    nxt_len = len_ff - LEN_W'(1);
                    nxt_state = nand_host_pkg::ST_RD_LO;
                end
                else
                begin
                    nxt_ce_n = 1'b1;
                    nxt_done = 1'b1;
                    nxt_req_ready = 1'b1;
                    nxt_state = nand_host_pkg::ST_IDLE;
                end
            end
            nand_host_pkg::ST_RDY_WAIT:
            begin
                // Busy line is not valid until the strobe-to-busy delay passes
                if (cnt_ff != '0)
                begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
                else if (rb_sync_ff)
                begin
                    nxt_done = 1'b1;
                    nxt_req_ready = 1'b1;
                    nxt_state = nand_host_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = nand_host_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; pins idle deselected, guard active
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= nand_host_pkg::ST_IDLE;
            op_ff <= nand_host_pkg::OP_CMD;
            addr_ff <= '0;
            len_ff <= '0;
            idx_ff <= '0;
            cnt_ff <= '0;
            {ce_n_ff, cle_ff, ale_ff, we_n_ff, re_n_ff, wp_n_ff} <= 6'h26;
            io_out_ff <= '0;
            io_oe_ff <= 1'b0;
            rd_data_ff <= '0;
            {rd_valid_ff, done_ff, err_ff, req_ready_ff, dev_ready_ff} <= 5'h00;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            len_ff <= nxt_len;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            {ce_n_ff, cle_ff, ale_ff} <= {nxt_ce_n, nxt_cle, nxt_ale};
            {we_n_ff, re_n_ff, wp_n_ff} <= {nxt_we_n, nxt_re_n, nxt_wp_n};
            io_out_ff <= nxt_io_out;
            io_oe_ff <= nxt_io_oe;
            rd_data_ff <= nxt_rd_data;
            {rd_valid_ff, done_ff, err_ff} <= {nxt_rd_valid, nxt_done, nxt_err};
            req_ready_ff <= nxt_req_ready;
            dev_ready_ff <= rb_sync_ff;
        end
    end

    // Two-stage synchronisers; the open-drain line is only ever read here
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            io_meta_ff <= '0;
            io_sync_ff <= '0;
            rb_meta_ff <= 1'b0;
            rb_sync_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            io_meta_ff <= io_in;
            io_sync_ff <= io_meta_ff;
            rb_meta_ff <= ready_busy_n;
            rb_sync_ff <= rb_meta_ff;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_rd_pulse;
        $fell(re_n_ff) ##[1:8] rd_valid_ff;
    endsequence

    chk_we_latch_state: assert property ($rose(we_n_ff) |-> !ce_n_ff && io_oe_ff
        && !(cle_ff && ale_ff)) else $error("write strobe rose with bad control");
    chk_cmd_opcode_legal: assert property ($rose(we_n_ff) && cle_ff
        |-> opc_legal(io_out_ff[7:0])) else $error("undefined opcode issued");
    chk_addr_last_low: assert property ($rose(we_n_ff) && ale_ff && idx_ff == LAST_ADDR
        |-> io_out_ff[7:2] == 6'h00) else $error("fifth address cycle high lines");
    chk_addr_upper_low: assert property (io_oe_ff && (ale_ff || cle_ff)
        |-> (io_out_ff >> 8) == '0) else $error("upper bus lines not low");
    chk_addr_count_max: assert property (ale_ff |-> idx_ff <= LAST_ADDR)
        else $error("more than five address cycles");
    chk_read_pulse_data: assert property (clk_en throughout $fell(re_n_ff)
        |-> s_rd_pulse) else $error("read pulse gave no data");
    chk_read_valid_rise: assert property (rd_valid_ff |-> $rose(re_n_ff) && !io_oe_ff)
        else $error("read data without strobe rise");
    chk_read_bus_free: assert property (!re_n_ff |-> !io_oe_ff && we_n_ff)
        else $error("bus driven during read");
    chk_busy_holds: assert property (state_ff == nand_host_pkg::ST_RDY_WAIT && !rb_sync_ff
        |=> !done_ff) else $error("done while device busy");
    chk_idle_deselect: assert property (state_ff == nand_host_pkg::ST_IDLE
        && $past(state_ff) == nand_host_pkg::ST_IDLE |-> ce_n_ff && !io_oe_ff)
        else $error("idle but selected");
endmodule

// File: tb/nand_dev_model.sv
`timescale 1ns/1ps
module nand_dev_model #(
    parameter int BUSY_NS = 3000
) (
    // Host strobes
    input wire logic clk,
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic wp_n,
    input wire logic [7:0] io_w,
    // Device drive
    output logic [7:0] dev_io,
    output logic rb_pull
);
    logic [7:0] cmd_ff = 8'h00; // Page read opcode preloaded at power-up
    logic [7:0] adr [5];
    logic [7:0] dat [$];
    logic [11:0] col = 12'h000;
    logic [7:0] rd_val = 8'h00;
    logic [7:0] idle_pat = 8'h3C; // Floating bus shows a changing pattern
    logic drv = 1'b0;
    int acnt = 0;
    int n_prog = 0;
    // Line 6 of the third cycle is the plane bit in both widths
    wire plane_sel = adr[2][6];
    initial rb_pull = 1'b0;
    // Latch only on write strobe rise while selected
    always @(posedge we_n) if (!ce_n)
    begin
        if (cle)
        begin
            cmd_ff = io_w;
            acnt = 0;
            if (io_w == 8'h30) col = {adr[1][3:0], adr[0]};
            // Program confirm refused while guard is low
            if (io_w == 8'h10 && wp_n) n_prog++;
            if (io_w == 8'h30 || (io_w == 8'h10 && wp_n)) busy();
        end
        else if (ale)
        begin
            if (acnt < 5) adr[acnt] = io_w; // Extra cycles dropped
            acnt++;
        end
        else dat.push_back(io_w);
    end
    // Pull the open-drain line low only while busy
    task automatic busy();
        fork
            begin
                rb_pull = 1'b1;
                #BUSY_NS rb_pull = 1'b0;
            end
        join_none
    endtask
    // Each read pulse while selected and not busy drives the next column after the access delay
    always @(negedge re_n) if (!ce_n && !rb_pull)
    begin
        #20 rd_val = col[7:0] ^ 8'hA5;
        drv = 1'b1;
        col++;
    end
    // Release soon after the pulse ends or on deselect
    always @(posedge re_n or posedge ce_n) #10 drv = 1'b0;
    always @(posedge clk) idle_pat <= ~idle_pat;
    assign dev_io = drv ? rd_val : idle_pat;
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, resetn, req_valid, req_ready, program_enable, wr_valid, wr_ready, rd_valid;
    logic done, err, dev_ready, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_pull;
    nand_host_pkg::op_t req_op;
    logic [7:0] req_byte, wr_data, rd_data, io_out, dev_io;
    logic [29:0] req_addr;
    logic [11:0] req_len;
    logic [7:0] rq [$];
    logic e;
    int n_mismatch = 0;
    int total_checks = 0;
    nand_host DUT (.clk(clk), .resetn(resetn), .clk_en(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_byte(req_byte), .req_addr(req_addr),
        .req_len(req_len), .program_enable(program_enable), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .done(done), .err(err), .dev_ready(dev_ready), .ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_in(io_oe ? io_out : dev_io),
        .io_out(io_out), .io_oe(io_oe), .ready_busy_n(~rb_pull));
    nand_dev_model M (.clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .wp_n(wp_n), .io_w(io_out), .dev_io(dev_io), .rb_pull(rb_pull));
    // Collect every read word as it is handed out
    always @(posedge clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One request, raised once the port is ready and held one cycle, then bounded wait for done or err
    task automatic req(input nand_host_pkg::op_t op, input logic [7:0] b,
        input logic [29:0] a, input logic [11:0] n);
        int k;
        int lim;
        for (k = 0; k < 50 && req_ready !== 1'b1; k++) begin @(posedge clk); #1; end
        // A port that never turns ready counts as a timeout as well
        lim = (k == 50) ? 0 : 400;
        req_op = op;
        req_byte = b;
        req_addr = a;
        req_len = n;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        for (k = 0; k < lim && done !== 1'b1 && err !== 1'b1; k++) begin @(posedge clk); #1; end
        if (k == lim)
        begin
            $display("BAD %0t request timed out", $time);
            n_mismatch++;
            results();
        end
        else e = err;
    endtask
    task automatic t_cmd();
        req(nand_host_pkg::OP_CMD, 8'h01, 0, 0);
        chk(e === 1'b1 && M.cmd_ff === 8'h00, "undefined opcode passed");
        req(nand_host_pkg::OP_CMD, 8'h90, 0, 0);
        chk(e === 1'b0 && M.cmd_ff === 8'h90, "command not latched");
        chk(ce_n === 1'b1 && io_oe === 1'b0, "bus held after command");
        $display("test cmd done");
    endtask
    task automatic t_addr(input logic [29:0] a);
        req(nand_host_pkg::OP_ADDR, 0, a, 0);
        chk(M.adr[0] === a[7:0] && M.adr[1] === {4'h0, a[11:8]}, "column bytes");
        chk(M.adr[2] === a[19:12] && M.adr[3] === a[27:20], "row bytes");
        chk(M.adr[4] === {6'h00, a[29:28]} && M.acnt == 5, "last address cycle");
        chk(M.plane_sel === a[18], "plane bit position");
        $display("test addr done");
    endtask
    task automatic t_write();
        int i;
        for (i = 0; i < 12 && wr_ready === 1'b1; i++)
        begin
            wr_data = 8'hC0 + 8'(i);
            wr_valid = 1'b1;
            @(posedge clk);
            #1;
        end
        wr_valid = 1'b0;
        chk(i == 8, "buffer depth");
        M.dat.delete();
        req(nand_host_pkg::OP_CMD, 8'h80, 0, 0);
        t_addr(30'h3A5C93E7);
        req(nand_host_pkg::OP_WRITE, 0, 0, 12'd8);
        chk(M.dat.size() == 8, "data word count");
        for (i = 0; i < 8; i++) chk(M.dat[i] === 8'hC0 + 8'(i), "data word");
        req(nand_host_pkg::OP_CMD, 8'h10, 0, 0);
        chk(rb_pull === 1'b1 && M.n_prog == 1, "program not started");
        req(nand_host_pkg::OP_WAIT_RDY, 0, 0, 0);
        chk(rb_pull === 1'b0 && dev_ready === 1'b1, "ready not seen");
        program_enable = 1'b0;
        req(nand_host_pkg::OP_CMD, 8'h10, 0, 0);
        chk(wp_n === 1'b0 && M.n_prog == 1, "guard ignored");
        program_enable = 1'b1;
        $display("test write done");
    endtask
    task automatic t_read();
        int i;
        logic [11:0] c;
        c = 12'hFFE;
        req(nand_host_pkg::OP_CMD, 8'h00, 0, 0);
        t_addr({18'h2AAAA, c});
        req(nand_host_pkg::OP_CMD, 8'h30, 0, 0);
        req(nand_host_pkg::OP_WAIT_RDY, 0, 0, 0);
        rq.delete();
        req(nand_host_pkg::OP_READ, 0, 0, 12'd4);
        chk(rq.size() == 4, "read word count");
        for (i = 0; i < 4; i++) chk(rq[i] === ((c + 12'(i)) & 12'hFF) ^ 8'hA5, "word");
        $display("test read done");
    endtask
    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        {resetn, req_valid, wr_valid, req_byte, wr_data} = 0;
        {req_addr, req_len} = 0;
        req_op = nand_host_pkg::OP_CMD;
        program_enable = 1'b1;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        t_cmd();
        t_write();
        t_read();
        results();
    end
endmodule
